// ===== rtl/dcl_cycle_ctrl.v
// Purpose: descriptor fetch, transfer and write-back for a DMA controller
// Assumes: bus slave answers with ready and error, after any number of wait states
// Notes:   fixed-priority arbitration, lowest channel first
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "dcl_defines.vh"
module dcl_cycle_ctrl
#(
   parameter NCH = 6
)
(
   input  wire            clk_i,
   input  wire            rst_n_i,
   input  wire [3:0]      reg_addr_i,
   input  wire [31:0]     reg_wdata_i,
   input  wire            reg_wr_i,
   input  wire            reg_rd_i,
   output reg  [31:0]     reg_rdata_o,
   output reg             bus_req_o,
   output reg             bus_we_o,
   output reg  [31:0]     bus_addr_o,
   output reg  [31:0]     bus_wdata_o,
   output reg  [1:0]      bus_size_o,
   input  wire [31:0]     bus_rdata_i,
   input  wire            bus_ready_i,
   input  wire            bus_err_i,
   input  wire [NCH-1:0]  req_burst_i,
   input  wire [NCH-1:0]  req_single_i,
   input  wire            energy_manager_wake_i,
   output wire            clk_req_o,
   output reg  [NCH-1:0]  done_o,
   output reg             err_o,
   output wire            irq_o
);
   localparam S_IDLE = 4'h0;
   localparam S_RCFG = 4'h1;
   localparam S_RSRC = 4'h2;
   localparam S_RDST = 4'h3;
   localparam S_RDAT = 4'h4;
   localparam S_WDAT = 4'h5;
   localparam S_WCFG = 4'h7;
   localparam S_DONE = 4'h9;

   reg [3:0]     st_r;
   reg           en_r;
   reg [31:0]    base_r;
   reg [NCH-1:0] chen_r;
   reg [NCH-1:0] burst_only_r;
   reg [NCH-1:0] unmask_r;
   reg [NCH-1:0] alt_r;
   reg [NCH:0]   if_r;
   reg [NCH:0]   ien_r;
   reg [NCH-1:0] pend_r;
   reg [2:0]     ch_r;
   reg [31:0]    cfg_r;
   reg [31:0]    sptr_r;
   reg [31:0]    dptr_r;
   reg [31:0]    data_r;
   reg [10:0]    left_r;
   reg [10:0]    per_r;
   reg [NCH-1:0] done_nxt;
   reg           err_nxt;
   reg [NCH-1:0] pick;
   reg [2:0]     pick_ch;
   integer       i;

   wire [2:0]  kind_w  = cfg_r[`DCL_F_KIND_LO+2:`DCL_F_KIND_LO];
   wire [9:0]  cnt_w   = cfg_r[`DCL_F_CNT_HI:`DCL_F_CNT_LO];
   wire [3:0]  rpow_w  = cfg_r[`DCL_F_RPOW_HI:`DCL_F_RPOW_LO];
   wire [1:0]  ssize_w = cfg_r[`DCL_F_SSIZE_HI:`DCL_F_SSIZE_LO];
   wire [1:0]  sinc_w  = cfg_r[`DCL_F_SINC_HI:`DCL_F_SINC_LO];
   wire [1:0]  dinc_w  = cfg_r[`DCL_F_DINC_HI:`DCL_F_DINC_LO];
   wire        isalt_w = alt_r[ch_r];
   wire [31:0] saddr_w;
   wire [31:0] daddr_w;
   wire [7:0]  desc_off_w = {isalt_w, ch_r, 4'h0};
   wire [31:0] desc_w = base_r | {24'h0, desc_off_w};
   // Single requests masked by burst-only flag
   wire [NCH-1:0] live_w = (req_burst_i | (req_single_i & ~burst_only_r)) & unmask_r;

   wire [10:0] period_w = (rpow_w > `DCL_RPOW_MAX) ? 11'h400 : (11'h1 << rpow_w);
   wire [10:0] total_w  = {1'b0, cnt_w} + 11'h1;

   dcl_addr_gen u_src
   (
      .end_ptr_i (sptr_r),
      .count_i   (cnt_w - left_r[9:0]),
      .inc_i     (sinc_w),
      .addr_o    (saddr_w)
   );
   dcl_addr_gen u_dst
   (
      .end_ptr_i (dptr_r),
      .count_i   (cnt_w - left_r[9:0]),
      .inc_i     (dinc_w),
      .addr_o    (daddr_w)
   );

   assign irq_o = |(if_r & ien_r);
   // Clock request while work or wake pending
   assign clk_req_o = energy_manager_wake_i | (st_r != S_IDLE) | (|(pend_r & chen_r));
   always @*
   begin
      done_nxt = {NCH{1'b0}};
      // Done pulse for basic and auto
      if (st_r == S_DONE && kind_w != `DCL_K_PINGPONG && !kind_w[2])
         done_nxt[ch_r] = 1'b1;
      err_nxt = bus_req_o & bus_err_i;
   end

   always @*
   begin
      pick = {NCH{1'b0}};
      pick_ch = 3'h0;
      for (i = NCH-1; i >= 0; i = i - 1)
      begin
         if (chen_r[i] & pend_r[i])
         begin
            pick = {NCH{1'b0}};
            pick[i] = 1'b1;
            pick_ch = i[2:0];
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_r <= S_IDLE;
         en_r <= 1'b0;
         base_r <= `DCL_BASE_RST;
         chen_r <= {NCH{1'b0}};
         burst_only_r <= {NCH{1'b0}};
         unmask_r <= {NCH{1'b0}};
         alt_r <= {NCH{1'b0}};
         if_r <= {(NCH+1){1'b0}};
         ien_r <= {(NCH+1){1'b0}};
         pend_r <= {NCH{1'b0}};
         ch_r <= 3'h0;
         cfg_r <= 32'h0;
         sptr_r <= 32'h0;
         dptr_r <= 32'h0;
         data_r <= 32'h0;
         left_r <= 11'h0;
         per_r <= 11'h0;
         done_o <= {NCH{1'b0}};
         err_o <= 1'b0;
         bus_req_o <= 1'b0;
         bus_we_o <= 1'b0;
         bus_addr_o <= 32'h0;
         bus_wdata_o <= 32'h0;
         bus_size_o <= 2'h0;
         reg_rdata_o <= 32'h0;
      end
      else
      begin
         pend_r <= pend_r | live_w;
         bus_req_o <= 1'b0;
         bus_we_o <= 1'b0;
         if (reg_wr_i)
         begin
            case (reg_addr_i)
               `DCL_REG_CONFIG: en_r <= reg_wdata_i[0];
               `DCL_REG_BASE:   base_r <= {reg_wdata_i[31:8], 8'h00};
               `DCL_REG_ENABLE: chen_r <= reg_wdata_i[NCH-1:0];
               `DCL_REG_BURST:  burst_only_r <= reg_wdata_i[NCH-1:0];
               `DCL_REG_UNMASK: unmask_r <= reg_wdata_i[NCH-1:0];
               `DCL_REG_ALT:    alt_r <= reg_wdata_i[NCH-1:0];
               `DCL_REG_IEN:    ien_r <= reg_wdata_i[NCH:0];
               default:         ;
            endcase
         end
         case (st_r)
            S_IDLE:
            begin
               if (en_r && (|pick))
               begin
                  ch_r <= pick_ch;
                  st_r <= S_RCFG;
               end
            end
            S_RCFG:
            begin
               bus_req_o <= 1'b1;
               bus_addr_o <= desc_w | {28'h0, `DCL_DESC_CFG};
               if (bus_req_o && bus_ready_i)
               begin
                  bus_req_o <= 1'b0;
                  cfg_r <= bus_rdata_i;
                  left_r <= 11'h0;
                  // Stop code: invalid descriptor ends the channel
                  if (bus_rdata_i[2:0] == `DCL_K_STOP)
                  begin
                     chen_r[ch_r] <= 1'b0;
                     pend_r[ch_r] <= 1'b0;
                     st_r <= S_IDLE;
                  end
                  else
                     st_r <= S_RSRC;
               end
            end
            S_RSRC:
            begin
               bus_req_o <= 1'b1;
               bus_addr_o <= desc_w | {28'h0, `DCL_DESC_SRC};
               if (bus_req_o && bus_ready_i)
               begin
                  bus_req_o <= 1'b0;
                  sptr_r <= bus_rdata_i;
                  st_r <= S_RDST;
               end
            end
            S_RDST:
            begin
               bus_req_o <= 1'b1;
               bus_addr_o <= desc_w | {28'h0, `DCL_DESC_DST};
               if (bus_req_o && bus_ready_i)
               begin
                  bus_req_o <= 1'b0;
                  dptr_r <= bus_rdata_i;
                  // Count plus one, capped by period
                  per_r <= (total_w < period_w) ? total_w : period_w;
                  st_r <= S_RDAT;
               end
            end
            S_RDAT:
            begin
               bus_req_o <= 1'b1;
               bus_addr_o <= saddr_w;
               bus_size_o <= ssize_w;
               if (bus_req_o && bus_ready_i)
               begin
                  bus_req_o <= 1'b0;
                  data_r <= bus_rdata_i;
                  st_r <= S_WDAT;
               end
            end
            S_WDAT:
            begin
               bus_req_o <= 1'b1;
               bus_we_o <= 1'b1;
               bus_addr_o <= daddr_w;
               bus_wdata_o <= data_r;
               if (bus_req_o && bus_ready_i)
               begin
                  bus_req_o <= 1'b0;
                  bus_we_o <= 1'b0;
                  left_r <= left_r + 11'h1;
                  st_r <= (left_r + 11'h1 == per_r) ? S_WCFG : S_RDAT;
               end
            end
            S_WCFG:
            begin
               bus_req_o <= 1'b1;
               bus_we_o <= 1'b1;
               bus_addr_o <= desc_w | {28'h0, `DCL_DESC_CFG};
               bus_wdata_o <= {dinc_w, ssize_w, cfg_r[27:14], cnt_w - per_r[9:0],
                               cfg_r[3], kind_w};
               if (per_r == total_w)
                  bus_wdata_o[13:0] <= {10'h0, cfg_r[`DCL_F_NXTBURST], `DCL_K_STOP};
               if (bus_req_o && bus_ready_i)
               begin
                  bus_req_o <= 1'b0;
                  bus_we_o <= 1'b0;
                  if (per_r == total_w)
                     st_r <= S_DONE;
                  else
                  begin
                     pend_r[ch_r] <= (kind_w == `DCL_K_AUTO) | live_w[ch_r];
                     st_r <= S_IDLE;
                  end
               end
            end
            S_DONE:
            begin
               if (isalt_w)
               begin
                  if (total_w < period_w)
                     burst_only_r[ch_r] <= 1'b0;
                  if (kind_w == `DCL_K_PSG_ALT && cfg_r[`DCL_F_NXTBURST])
                     burst_only_r[ch_r] <= 1'b1;
               end
               if (kind_w == `DCL_K_PINGPONG || kind_w[2])
                  alt_r[ch_r] <= ~isalt_w;
               else
               begin
                  // Basic and auto end the channel
                  chen_r[ch_r] <= 1'b0;
               end
               pend_r[ch_r] <= (kind_w == `DCL_K_PINGPONG) ? live_w[ch_r] : kind_w[2];
               st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
         if (err_nxt)
         begin
            chen_r[ch_r] <= 1'b0;
            pend_r[ch_r] <= 1'b0;
            bus_req_o <= 1'b0;
            bus_we_o <= 1'b0;
            st_r <= S_IDLE;
         end
         done_o <= done_nxt;
         err_o <= err_nxt;
         // Set wins over clear
         if_r <= (reg_wr_i && reg_addr_i == `DCL_REG_IFC ?
                  if_r & ~reg_wdata_i[NCH:0] : if_r) | {err_nxt, done_nxt};
         reg_rdata_o <= 32'h0;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               `DCL_REG_CONFIG: reg_rdata_o <= {31'h0, en_r};
               `DCL_REG_BASE:   reg_rdata_o <= base_r;
               `DCL_REG_ENABLE: reg_rdata_o <= {{(32-NCH){1'b0}}, chen_r};
               `DCL_REG_BURST:  reg_rdata_o <= {{(32-NCH){1'b0}}, burst_only_r};
               `DCL_REG_UNMASK: reg_rdata_o <= {{(32-NCH){1'b0}}, unmask_r};
               `DCL_REG_ALT:    reg_rdata_o <= {{(32-NCH){1'b0}}, alt_r};
               `DCL_REG_IF:     reg_rdata_o <= {{(31-NCH){1'b0}}, if_r};
               `DCL_REG_IEN:    reg_rdata_o <= {{(31-NCH){1'b0}}, ien_r};
               `DCL_REG_STATUS: reg_rdata_o <= {24'h0, st_r, 3'h0, en_r};
               default:         reg_rdata_o <= 32'h0;
            endcase
         end
      end
   end
endmodule

// ===== pkg/dcl_defines.vh
// Purpose: constants for the DMA descriptor cycle logic
// Assumes: one core clock, 100 MHz
// Notes:   descriptor word layout and register offsets
// What this block does
// - Exponent b1000 re-arbitrates after 256 transfers, b1001 after 512.
// - Exponent codes above b1001 never re-arbitrate within a cycle.
// - Bits [13:4] hold transfer count minus one.
// - Count field rewritten with outstanding transfers before arbitration.
// - Peripheral scatter alternate done with bit 3 set sets burst-only.
// - Alternate cycle end clears burst-only if fewer than period remain.
// - Burst-only clear answers both request lines, set answers burst only.
// - Cycle kind in [2:0]; stop invalid; basic needs request per period.
// - Auto-request inserts its own request each arbitration.
// - Ping-pong alternates descriptors until invalid or mode changed.
// - Control word fetched per period, written back after it.
// - Destination width mismatch: use source width, overwrite at update.
// - Cycle done writes b000 into cycle kind.
// - Address is end pointer minus count shifted by step code.
// - Step code b11 uses end pointer unchanged.
// - Energy manager can wake the block for peripheral transfers.
// - Done and error flags with enables merge into one interrupt.
// - Done pulses one core clock cycle, then arbitration.
// - Bus error disables active channel and raises error.
// - Width b00 byte, b01 halfword, b10 word, b11 reserved.
`ifndef DCL_DEFINES_VH
`define DCL_DEFINES_VH
`define DCL_F_KIND_LO     0
`define DCL_F_NXTBURST    3
`define DCL_F_CNT_LO      4
`define DCL_F_CNT_HI      13
`define DCL_F_RPOW_LO     14
`define DCL_F_RPOW_HI     17
`define DCL_F_SSIZE_LO    24
`define DCL_F_SSIZE_HI    25
`define DCL_F_SINC_LO     26
`define DCL_F_SINC_HI     27
`define DCL_F_DSIZE_LO    28
`define DCL_F_DSIZE_HI    29
`define DCL_F_DINC_LO     30
`define DCL_F_DINC_HI     31
`define DCL_K_STOP        3'h0
`define DCL_K_BASIC       3'h1
`define DCL_K_AUTO        3'h2
`define DCL_K_PINGPONG    3'h3
`define DCL_K_MSG_PRI     3'h4
`define DCL_K_MSG_ALT     3'h5
`define DCL_K_PSG_PRI     3'h6
`define DCL_K_PSG_ALT     3'h7
`define DCL_RPOW_MAX      4'h9
`define DCL_INC_NONE      2'h3
`define DCL_W_RESERVED    2'h3
`define DCL_DESC_SRC      4'h0
`define DCL_DESC_DST      4'h4
`define DCL_DESC_CFG      4'h8
`define DCL_ALT_BIT       7
`define DCL_REG_CONFIG    4'h0
`define DCL_REG_BASE      4'h1
`define DCL_REG_ENABLE    4'h2
`define DCL_REG_BURST     4'h3
`define DCL_REG_UNMASK    4'h4
`define DCL_REG_ALT       4'h5
`define DCL_REG_IF        4'h6
`define DCL_REG_IFC       4'h7
`define DCL_REG_IEN       4'h8
`define DCL_REG_STATUS    4'h9
`define DCL_BASE_RST      32'h0000_0000
`endif

// ===== rtl/dcl_addr_gen.v
// Purpose: transfer address from end pointer and remaining count
// Assumes: count is the live remaining-minus-one value
// Notes:   combinational
`timescale 1ns/1ps
`include "dcl_defines.vh"
module dcl_addr_gen
(
   input  wire [31:0] end_ptr_i,
   input  wire [9:0]  count_i,
   input  wire [1:0]  inc_i,
   output reg  [31:0] addr_o
);
   wire [31:0] cnt_w;
   assign cnt_w = {22'h0, count_i};
   always @*
   begin
      if (inc_i == `DCL_INC_NONE)
         addr_o = end_ptr_i;
      else
         addr_o = end_ptr_i - (cnt_w << inc_i);
   end
endmodule

// ===== test/dcl_cycle_chk.sv
// Purpose: timing checks on the cycle controller ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached by bind to every controller instance
`timescale 1ns/1ps
module dcl_cycle_chk
#(
   parameter NCH = 6
)
(
   input wire logic           clk_i,
   input wire logic           rst_n_i,
   input wire logic           bus_req_o,
   input wire logic           bus_we_o,
   input wire logic [31:0]    bus_addr_o,
   input wire logic [31:0]    bus_wdata_o,
   input wire logic           bus_ready_i,
   input wire logic           bus_err_i,
   input wire logic           energy_manager_wake_i,
   input wire logic           clk_req_o,
   input wire logic [NCH-1:0] done_o,
   input wire logic           err_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   done_pulse_a: assert property (done_o != 0 |=> done_o == 0)
      else $error("done held longer than one cycle");
   done_single_a: assert property ($onehot0(done_o))
      else $error("several done bits at once");
   err_pulse_a: assert property (err_o |=> !err_o)
      else $error("error held longer than one cycle");
   err_cause_a: assert property ($rose(err_o) |-> $past(bus_err_i && bus_req_o))
      else $error("error raised without a bus error");
   wake_clock_a: assert property (energy_manager_wake_i |-> clk_req_o)
      else $error("wake did not keep the clock on");
   req_hold_a: assert property (bus_req_o && !bus_ready_i |=>
      bus_req_o && $stable(bus_addr_o) && $stable(bus_we_o))
      else $error("access changed before ready");
   wdata_hold_a: assert property (bus_req_o && bus_we_o && !bus_ready_i |=>
      $stable(bus_wdata_o))
      else $error("write data changed before ready");
   req_drop_a: assert property (bus_req_o && bus_ready_i |=> !bus_req_o)
      else $error("access not released after ready");
endmodule
bind dcl_cycle_ctrl dcl_cycle_chk #(.NCH(NCH)) i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .bus_req_o(bus_req_o), .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o),
   .bus_wdata_o(bus_wdata_o), .bus_ready_i(bus_ready_i), .bus_err_i(bus_err_i),
   .energy_manager_wake_i(energy_manager_wake_i), .clk_req_o(clk_req_o),
   .done_o(done_o), .err_o(err_o));

// ===== test/dcl_mem_model.sv
// Purpose: system memory holding descriptors and data
// Assumes: word accesses, 256 words, address bits [9:2]
// Notes:   wait states and error answer set by the bench
`timescale 1ns/1ps
module dcl_mem_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        bus_req_i,
   input  wire logic        bus_we_i,
   input  wire logic [31:0] bus_addr_i,
   input  wire logic [31:0] bus_wdata_i,
   input  wire logic [1:0]  wait_i,
   input  wire logic        fail_i,
   output logic      [31:0] bus_rdata_o,
   output logic             bus_ready_o,
   output logic             bus_err_o
);
   logic [31:0] mem [0:255];
   logic [1:0]  cnt_r;
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r       <= 2'h0;
         bus_ready_o <= 1'b0;
         bus_err_o   <= 1'b0;
         bus_rdata_o <= 32'h0;
      end
      else
      begin
         bus_ready_o <= 1'b0;
         bus_err_o   <= 1'b0;
         // Stale data flips so nothing passes by luck
         bus_rdata_o <= ~bus_rdata_o;
         if (bus_req_i && !bus_ready_o)
         begin
            if (cnt_r == wait_i)
            begin
               cnt_r       <= 2'h0;
               bus_ready_o <= 1'b1;
               bus_err_o   <= fail_i;
               bus_rdata_o <= mem[bus_addr_i[9:2]];
               if (bus_we_i && !fail_i)
                  mem[bus_addr_i[9:2]] <= bus_wdata_i;
            end
            else
               cnt_r <= cnt_r + 2'h1;
         end
      end
   end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench for the cycle controller
// Assumes: descriptor base 0, word data
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "dcl_defines.vh"
module testbench;
   logic        clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, wake = 0, fail_r = 0;
   logic [3:0]  reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, reg_rdata_o, bus_addr_o, bus_wdata_o, bus_rdata_i;
   logic        bus_req_o, bus_we_o, bus_ready_i, bus_err_i, clk_req_o, err_o, irq_o;
   logic [1:0]  bus_size_o, wait_r = 0;
   logic [5:0]  req_burst_i = 0, req_single_i = 0, done_o;
   int          n_errors = 0, checks_done = 0, cyc = 0;
   dcl_cycle_ctrl #(.NCH(6)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o),
      .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_size_o(bus_size_o),
      .bus_rdata_i(bus_rdata_i), .bus_ready_i(bus_ready_i), .bus_err_i(bus_err_i),
      .req_burst_i(req_burst_i), .req_single_i(req_single_i), .energy_manager_wake_i(wake),
      .clk_req_o(clk_req_o), .done_o(done_o), .err_o(err_o), .irq_o(irq_o));
   dcl_mem_model i_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_o),
      .bus_we_i(bus_we_o), .bus_addr_i(bus_addr_o), .bus_wdata_i(bus_wdata_o),
      .wait_i(wait_r), .fail_i(fail_r), .bus_rdata_o(bus_rdata_i),
      .bus_ready_o(bus_ready_i), .bus_err_o(bus_err_i));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1 check(reg_rdata_o, exp);
   endtask
   function automatic logic [31:0] cfg(input logic [2:0] k, input logic [9:0] n,
      input logic [3:0] rp, input logic [1:0] dsz, input logic [1:0] dinc);
      cfg = {dinc, dsz, 2'h2, 2'h2, 6'h0, rp, n, 1'b0, k};
   endfunction
   task automatic start(input int ch, input logic [31:0] c, input logic [31:0] s,
      input logic [31:0] d, input logic [31:0] burst);
      i_mem.mem[ch*4]   = s;
      i_mem.mem[ch*4+1] = d;
      i_mem.mem[ch*4+2] = c;
      wr(`DCL_REG_CONFIG, 32'h1);
      wr(`DCL_REG_BURST, burst);
      wr(`DCL_REG_UNMASK, 32'h1 << ch);
      wr(`DCL_REG_ALT, 32'h0);
      wr(`DCL_REG_ENABLE, 32'h1 << ch);
   endtask
   task automatic wait_done(input int ch);
      int k;
      k = 0;
      while (done_o[ch] !== 1'b1 && k < 3000)
      begin
         @(posedge clk_i);
         #1 k++;
      end
      check({31'h0, done_o[ch]}, 32'h1);
   endtask
   task automatic test_regs();
      rd(`DCL_REG_BURST, 32'h0);
      wr(4'hc, 32'hffff_ffff);
      rd(4'hc, 32'h0);
      @(posedge clk_i);
      wake <= 1'b1;
      #1 check({31'h0, clk_req_o}, 32'h1);
      @(posedge clk_i);
      wake <= 1'b0;
      #1 check({31'h0, clk_req_o}, 32'h0);
   endtask
   task automatic test_auto();
      for (int i = 0; i < 4; i++)
      begin
         i_mem.mem[8'h80+i] = 32'ha0 + i;
         i_mem.mem[8'hc0+i] = 32'h0;
      end
      wr(`DCL_REG_IEN, 32'h1);
      // Width mismatch: destination half, source word
      start(0, cfg(`DCL_K_AUTO, 10'h3, 4'h1, 2'h1, 2'h2), 32'h20c, 32'h30c, 32'h0);
      @(posedge clk_i);
      req_burst_i[0] <= 1'b1;
      repeat (3) @(posedge clk_i);
      req_burst_i[0] <= 1'b0;
      wait_done(0);
      check({31'h0, irq_o}, 32'h1);
      check({30'h0, bus_size_o}, 32'h2);
      for (int i = 0; i < 4; i++)
         check(i_mem.mem[8'hc0+i], 32'ha0 + i);
      check(i_mem.mem[2], cfg(`DCL_K_STOP, 10'h0, 4'h1, 2'h2, 2'h2));
      wr(`DCL_REG_IFC, 32'h1);
      #1 check({31'h0, irq_o}, 32'h0);
   endtask
   task automatic test_basic();
      i_mem.mem[8'h84] = 32'hb0;
      i_mem.mem[8'h85] = 32'hb1;
      i_mem.mem[8'hc7] = 32'h55;
      // Fixed destination: both words land on the end pointer
      start(1, cfg(`DCL_K_BASIC, 10'h1, 4'h0, 2'h2, 2'h3), 32'h214, 32'h320, 32'h2);
      @(posedge clk_i);
      req_burst_i[1] <= 1'b1;
      repeat (3) @(posedge clk_i);
      req_burst_i[1] <= 1'b0;
      // No fresh request: channel parks after one period
      repeat (60) @(posedge clk_i);
      check(i_mem.mem[6], cfg(`DCL_K_BASIC, 10'h0, 4'h0, 2'h2, 2'h3));
      req_burst_i[1] <= 1'b1;
      wait_done(1);
      req_burst_i[1] <= 1'b0;
      check(i_mem.mem[8'hc8], 32'hb1);
      check(i_mem.mem[8'hc7], 32'h55);
      check(i_mem.mem[6], cfg(`DCL_K_STOP, 10'h0, 4'h0, 2'h2, 2'h3));
   endtask
   task automatic test_err();
      int k;
      k = 0;
      wait_r <= 2'h2;
      fail_r <= 1'b1;
      start(2, cfg(`DCL_K_AUTO, 10'h0, 4'h0, 2'h2, 2'h2), 32'h200, 32'h300, 32'h0);
      req_burst_i[2] <= 1'b1;
      while (err_o !== 1'b1 && k < 500)
      begin
         @(posedge clk_i);
         #1 k++;
      end
      check({31'h0, err_o}, 32'h1);
      fail_r <= 1'b0;
      req_burst_i[2] <= 1'b0;
      rd(`DCL_REG_ENABLE, 32'h0);
      rd(`DCL_REG_IF, 32'h42);
   endtask
   task automatic test_sg(input int ch, input logic [2:0] kp, input logic [2:0] ka,
      input logic [3:0] rp, input logic [31:0] b_in, input logic [31:0] b_exp);
      logic [31:0] c;
      c = cfg(`DCL_K_STOP, 10'h0, rp, 2'h2, 2'h2) | 32'h8;
      for (int i = 0; i < 4; i++)
      begin
         i_mem.mem[8'h80+i] = 32'h100 * ch + i;
         i_mem.mem[8'hc0+i] = 32'h0;
      end
      // Alternate copy, refreshed by the host before use
      i_mem.mem[32+ch*4] = 32'h20c;
      i_mem.mem[33+ch*4] = 32'h30c;
      i_mem.mem[34+ch*4] = cfg(ka, 10'h1, rp, 2'h2, 2'h2) | 32'h8;
      start(ch, cfg(kp, 10'h1, rp, 2'h2, 2'h2) | 32'h8, 32'h204, 32'h304, b_in);
      @(posedge clk_i);
      req_burst_i[ch] <= 1'b1;
      repeat (300) @(posedge clk_i);
      req_burst_i[ch] <= 1'b0;
      for (int i = 0; i < 4; i++)
         check(i_mem.mem[8'hc0+i], 32'h100 * ch + i);
      check(i_mem.mem[ch*4+2], c);
      check(i_mem.mem[34+ch*4], c);
      rd(`DCL_REG_BURST, b_exp);
      rd(`DCL_REG_ALT, 32'h0);
      rd(`DCL_REG_ENABLE, 32'h0);
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      test_regs();
      test_auto();
      test_basic();
      test_err();
      test_sg(3, `DCL_K_PSG_PRI, `DCL_K_PSG_ALT, 4'h1, 32'h0, 32'h8);
      test_sg(4, `DCL_K_MSG_PRI, `DCL_K_MSG_ALT, 4'h2, 32'h10, 32'h0);
      test_sg(5, `DCL_K_PINGPONG, `DCL_K_PINGPONG, 4'h1, 32'h20, 32'h20);
      give_verdict();
   end
endmodule
